// ### rtl/pib_top.sv
/*
 * Peripheral interrupt bank with an AXI4-Lite register slave.
 * Assumes peripheral event inputs are single-cycle pulses or levels on clk,
 * except the comparator output which is an asynchronous pin.
 */
`timescale 1ns/1ps
`include "pib_params.svh"
module pib_top (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset,
   // AXI4-Lite write address
   input  wire logic [4:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [4:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Peripheral events
   input  wire logic                 eeprom_write_done,
   input  wire logic                 adc_done,
   input  wire logic                 capture_event,
   input  wire logic                 compare_event,
   input  wire pib_pkg::pib_cc_mode_t capcomp_mode,
   input  wire logic                 comparator_out,
   input  wire logic                 osc_failover,
   input  wire logic                 timer_b_match,
   input  wire logic                 timer_a_overflow,
   // Requests
   output logic                      peripheral_request,
   output logic                      core_irq,
   output logic                      irq
);

   // --------------------------------------------------------------------
   // Register state
   // --------------------------------------------------------------------
   logic [7:0] peripheral_irq_enable;
   logic       peripheral_group_enable;
   logic       global_irq_enable;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;

   pib_flag_if flag_bus ();

   pib_flag_bank u_bank (
      .clk   (clk),
      .reset (reset),
      .fi    (flag_bus)
   );

   // --------------------------------------------------------------------
   // Comparator synchroniser and edge detect
   // --------------------------------------------------------------------
   logic       cmp_s1;
   logic       cmp_s2;
   logic       cmp_s3;
   logic       cmp_level;
   logic [1:0] cmp_warm;
   logic       cmp_ready;
   logic       cmp_agree;
   logic       cmp_change;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
         cmp_s3 <= 1'b0;
      end else begin
         cmp_s1 <= comparator_out;
         cmp_s2 <= cmp_s1;
         cmp_s3 <= cmp_s2;
      end
   end

   // A change counts once the second and third stages agree on a level other
   // than the accepted one, so a one-cycle glitch on the pin is filtered out.
   assign cmp_ready  = cmp_warm == 2'h3;
   assign cmp_agree  = cmp_s2 == cmp_s3;
   assign cmp_change = cmp_ready && cmp_agree && (cmp_s3 != cmp_level);

   // Until the pin's own level has reached the last stage, the accepted level
   // follows silently, so a pin that idles high after reset is no false change.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cmp_warm  <= 2'h0;
         cmp_level <= 1'b0;
      end else if (!cmp_ready) begin
         cmp_warm  <= cmp_warm + 2'h1;
         cmp_level <= cmp_s2;
      end else if (cmp_agree) begin
         cmp_level <= cmp_s3;
      end
   end

   // --------------------------------------------------------------------
   // Event collection
   // --------------------------------------------------------------------
   wire cc_capture = (capcomp_mode == pib_pkg::PIB_CC_CAPTURE) && capture_event;
   wire cc_compare = (capcomp_mode == pib_pkg::PIB_CC_COMPARE) && compare_event;
   wire [7:0] events;

   assign events[`PIB_BIT_EEPROM]     = eeprom_write_done;
   assign events[`PIB_BIT_ADC]        = adc_done;
   assign events[`PIB_BIT_CAPCOMP]    = cc_capture | cc_compare;
   assign events[`PIB_BIT_UNUSED]     = 1'b0;
   assign events[`PIB_BIT_COMPARATOR] = cmp_change;
   assign events[`PIB_BIT_OSC_FAIL]   = osc_failover;
   assign events[`PIB_BIT_TIMER_B]    = timer_b_match;
   assign events[`PIB_BIT_TIMER_A]    = timer_a_overflow;

   assign flag_bus.event_set = events;

   // --------------------------------------------------------------------
   // AXI4-Lite write path
   // --------------------------------------------------------------------
   logic [4:0]  aw_addr;
   logic        aw_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        w_held;

   wire wr_go    = aw_held && w_held && !s_axi_bvalid;
   wire wr_lane0 = wr_go && w_strb[0];
   wire sel_en   = aw_addr == 5'(`PIB_OFS_ENABLE);
   wire sel_fl   = aw_addr == 5'(`PIB_OFS_FLAGS);
   wire sel_co   = aw_addr == 5'(`PIB_OFS_CORE);
   wire sel_st   = aw_addr == 5'(`PIB_OFS_IRQ_STAT);
   wire sel_mk   = aw_addr == 5'(`PIB_OFS_IRQ_MASK);
   wire wr_known = sel_en | sel_fl | sel_co | sel_st | sel_mk;

   // Writing zero to a flag clears it; ones are ignored.
   assign flag_bus.clear_mask = (wr_lane0 && sel_fl) ? ~w_data[7:0] : 8'h00;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aw_held <= 1'b0;
         aw_addr <= 5'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // Control registers
   // --------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         peripheral_irq_enable <= `PIB_RESET_BYTE;
      end else if (wr_lane0 && sel_en) begin
         peripheral_irq_enable <= w_data[7:0] & `PIB_IMPL_MASK;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         peripheral_group_enable <= 1'b0;
         global_irq_enable       <= 1'b0;
         irq_mask                <= 2'h0;
      end else if (wr_lane0 && sel_co) begin
         peripheral_group_enable <= w_data[`PIB_CORE_GROUP];
         global_irq_enable       <= w_data[`PIB_CORE_GLOBAL];
      end else if (wr_lane0 && sel_mk) begin
         irq_mask <= w_data[1:0];
      end
   end

   // --------------------------------------------------------------------
   // Requests and bus-side interrupt
   // --------------------------------------------------------------------
   wire       next_peripheral_request = |(flag_bus.flags & peripheral_irq_enable);
   wire       next_core_irq = global_irq_enable && peripheral_group_enable
                              && next_peripheral_request;
   wire [1:0] stat_events = {next_core_irq & ~core_irq,
                             next_peripheral_request & ~peripheral_request};
   wire [1:0] stat_clear  = (wr_lane0 && sel_st) ? w_data[1:0] : 2'h0;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         peripheral_request <= 1'b0;
         core_irq           <= 1'b0;
         irq_status         <= 2'h0;
         irq                <= 1'b0;
      end else begin
         peripheral_request <= next_peripheral_request;
         core_irq           <= next_core_irq;
         irq_status         <= (irq_status & ~stat_clear) | stat_events;
         irq                <= |(irq_status & irq_mask);
      end
   end

   // --------------------------------------------------------------------
   // AXI4-Lite read path
   // --------------------------------------------------------------------
   wire [4:0] rd_addr = s_axi_araddr;
   wire [7:0] rd_byte =
      (rd_addr == 5'(`PIB_OFS_ENABLE))   ? peripheral_irq_enable :
      (rd_addr == 5'(`PIB_OFS_FLAGS))    ? flag_bus.flags :
      (rd_addr == 5'(`PIB_OFS_CORE))     ? {6'h00, global_irq_enable,
                                             peripheral_group_enable} :
      (rd_addr == 5'(`PIB_OFS_IRQ_STAT)) ? {6'h00, irq_status} :
      (rd_addr == 5'(`PIB_OFS_IRQ_MASK)) ? {6'h00, irq_mask} : 8'h00;
   wire rd_known = (rd_addr == 5'(`PIB_OFS_ENABLE)) | (rd_addr == 5'(`PIB_OFS_FLAGS))
                 | (rd_addr == 5'(`PIB_OFS_CORE)) | (rd_addr == 5'(`PIB_OFS_IRQ_STAT))
                 | (rd_addr == 5'(`PIB_OFS_IRQ_MASK));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, rd_byte};
         s_axi_rresp  <= rd_known ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------------
   group_gate_a: assert property (@(posedge clk) disable iff (reset)
      !peripheral_group_enable |=> !core_irq)
      else $error("core request without group enable");
   global_gate_a: assert property (@(posedge clk) disable iff (reset)
      !global_irq_enable |=> !core_irq)
      else $error("core request without global enable");
   request_or_a: assert property (@(posedge clk) disable iff (reset)
      peripheral_request == $past(|(flag_bus.flags & peripheral_irq_enable)))
      else $error("request not the masked flag OR");
   enable_bit4_a: assert property (@(posedge clk) disable iff (reset)
      peripheral_irq_enable[`PIB_BIT_UNUSED] == 1'b0)
      else $error("enable bit four set");
   flag_set_a: assert property (@(posedge clk) disable iff (reset)
      timer_a_overflow |=> flag_bus.flags[`PIB_BIT_TIMER_A])
      else $error("timer A event lost");
   adc_set_a: assert property (@(posedge clk) disable iff (reset)
      adc_done |=> flag_bus.flags[`PIB_BIT_ADC])
      else $error("adc event lost");
   pwm_quiet_a: assert property (@(posedge clk) disable iff (reset)
      (capcomp_mode == pib_pkg::PIB_CC_PWM) |-> !events[`PIB_BIT_CAPCOMP])
      else $error("capture/compare event in pwm mode");
   cmp_flag_a: assert property (@(posedge clk) disable iff (reset)
      cmp_change |=> flag_bus.flags[`PIB_BIT_COMPARATOR])
      else $error("comparator change lost");
   osc_set_a: assert property (@(posedge clk) disable iff (reset)
      osc_failover |=> flag_bus.flags[`PIB_BIT_OSC_FAIL])
      else $error("oscillator fail lost");
   tb_set_a: assert property (@(posedge clk) disable iff (reset)
      timer_b_match |=> flag_bus.flags[`PIB_BIT_TIMER_B])
      else $error("timer B match lost");
   irq_level_a: assert property (@(posedge clk) disable iff (reset)
      irq == $past(|(irq_status & irq_mask)))
      else $error("interrupt not the masked status OR");
   stat_rise_a: assert property (@(posedge clk) disable iff (reset)
      $rose(peripheral_request) |-> irq_status[0])
      else $error("request rise not recorded");
   bresp_hold_a: assert property (@(posedge clk) disable iff (reset)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
      else $error("write response dropped early");
   rdata_hold_a: assert property (@(posedge clk) disable iff (reset)
      (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
      else $error("read data dropped early");
   write_busy_a: assert property (@(posedge clk) disable iff (reset)
      s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
      else $error("write taken during response");

   write_seen_c: cover property (@(posedge clk) disable iff (reset) wr_go && sel_en);
   clear_seen_c: cover property (@(posedge clk) disable iff (reset)
      flag_bus.clear_mask != 8'h00);
   core_irq_c:   cover property (@(posedge clk) disable iff (reset) $rose(core_irq));
   cmp_event_c:  cover property (@(posedge clk) disable iff (reset) cmp_change);
   irq_rise_c:   cover property (@(posedge clk) disable iff (reset) $rose(irq));

endmodule : pib_top

// ### rtl/pib_params.svh
/*
 * Register offsets, field positions and reset values of the peripheral
 * interrupt bank.
 * Assumes it is included by bare name from files under rtl/.
 */
`ifndef PIB_PARAMS_SVH
`define PIB_PARAMS_SVH

// -----------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------
`define PIB_OFS_ENABLE     5'h00
`define PIB_OFS_FLAGS      5'h04
`define PIB_OFS_CORE       5'h08
`define PIB_OFS_IRQ_STAT   5'h0c
`define PIB_OFS_IRQ_MASK   5'h10

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define PIB_BIT_EEPROM     7
`define PIB_BIT_ADC        6
`define PIB_BIT_CAPCOMP    5
`define PIB_BIT_UNUSED     4
`define PIB_BIT_COMPARATOR 3
`define PIB_BIT_OSC_FAIL   2
`define PIB_BIT_TIMER_B    1
`define PIB_BIT_TIMER_A    0
`define PIB_CORE_GLOBAL    1
`define PIB_CORE_GROUP     0

// -----------------------------------------------------------------------
// Reset values and masks
// -----------------------------------------------------------------------
`define PIB_RESET_BYTE     8'h00
`define PIB_IMPL_MASK      8'hef
`define PIB_CORE_MASK      8'h03
`define PIB_STAT_MASK      8'h03

`endif

// ### rtl/pib_pkg.sv
/*
 * Types shared by the peripheral interrupt bank modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pib_pkg;

   typedef enum logic [1:0] {
      PIB_CC_OFF,
      PIB_CC_CAPTURE,
      PIB_CC_COMPARE,
      PIB_CC_PWM
   } pib_cc_mode_t;

   typedef logic [7:0] pib_byte_t;

endpackage : pib_pkg

// ### rtl/pib_flag_if.sv
/*
 * Interface joining the register slave and the flag bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pib_flag_if;
   logic [7:0] event_set;
   logic [7:0] clear_mask;
   logic [7:0] flags;

   modport bank (input event_set, input clear_mask, output flags);
   modport ctrl (output event_set, output clear_mask, input flags);
endinterface : pib_flag_if

// ### rtl/pib_flag_bank.sv
/*
 * Sticky flag bank: hardware sets flags, software clears them.
 * Assumes event_set and clear_mask are synchronous to clk.
 */
`timescale 1ns/1ps
`include "pib_params.svh"
module pib_flag_bank (
   // Clock and reset
   input wire logic   clk,
   input wire logic   reset,
   // Flag traffic
   pib_flag_if.bank   fi
);

   logic [7:0] flag_q;
   logic [7:0] next_flag;

   // Set wins over a clear arriving in the same cycle; bit 4 never holds.
   assign next_flag = ((flag_q & ~fi.clear_mask) | fi.event_set)
                      & `PIB_IMPL_MASK;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flag_q <= `PIB_RESET_BYTE;
      end else begin
         flag_q <= next_flag;
      end
   end

   assign fi.flags = flag_q;

   sticky_hold_a: assert property (@(posedge clk) disable iff (reset)
      (flag_q[0] && !fi.clear_mask[0]) |=> flag_q[0])
      else $error("flag dropped without clear");
   unused_zero_a: assert property (@(posedge clk) disable iff (reset)
      flag_q[`PIB_BIT_UNUSED] == 1'b0)
      else $error("unimplemented flag bit set");

endmodule : pib_flag_bank

// ### bench/pib_periph_model.sv
/*
 * Behavioural model of the peripherals that raise events into the bank.
 * Assumes the bench calls its tasks from one process, one event at a time.
 */
`timescale 1ns/1ps
module pib_periph_model (
   // Clock
   input  wire logic              clk,
   // Event lines
   output logic                   eeprom_write_done,
   output logic                   adc_done,
   output logic                   capture_event,
   output logic                   compare_event,
   output pib_pkg::pib_cc_mode_t  capcomp_mode,
   output logic                   comparator_out,
   output logic                   osc_failover,
   output logic                   timer_b_match,
   output logic                   timer_a_overflow
);
   initial begin
      {eeprom_write_done, adc_done, capture_event, compare_event} = 4'h0;
      {comparator_out, osc_failover, timer_b_match, timer_a_overflow} = 4'h0;
      capcomp_mode = pib_pkg::PIB_CC_OFF;
   end

   task automatic set_mode(input pib_pkg::pib_cc_mode_t m);
      @(posedge clk);
      capcomp_mode <= m;
   endtask : set_mode

   // One cycle event; source 8 is a compare match, 3 toggles the comparator.
   task automatic pulse(input int src);
      @(posedge clk);
      case (src)
         7: eeprom_write_done <= 1'b1;
         6: adc_done <= 1'b1;
         5: capture_event <= 1'b1;
         8: compare_event <= 1'b1;
         3: comparator_out <= ~comparator_out;
         2: osc_failover <= 1'b1;
         1: timer_b_match <= 1'b1;
         default: timer_a_overflow <= 1'b1;
      endcase
      @(posedge clk);
      {eeprom_write_done, adc_done, capture_event, compare_event} <= 4'h0;
      {osc_failover, timer_b_match, timer_a_overflow} <= 3'h0;
   endtask : pulse
endmodule : pib_periph_model

// ### bench/pib_top_tb.sv
/*
 * Self-checking bench of the peripheral interrupt bank over AXI4-Lite.
 * Assumes the peripheral model file and the design files are compiled first.
 */
`timescale 1ns/1ps
module pib_top_tb;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   localparam logic [4:0] A_EN   = 5'h00;
   localparam logic [4:0] A_FL   = 5'h04;
   localparam logic [4:0] A_CORE = 5'h08;
   localparam logic [4:0] A_STAT = 5'h0c;
   localparam logic [4:0] A_MASK = 5'h10;
   logic                  clk, reset;
   logic [4:0]            s_axi_awaddr, s_axi_araddr;
   logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                  s_axi_rvalid, s_axi_rready;
   logic [31:0]           s_axi_wdata, s_axi_rdata;
   logic [3:0]            s_axi_wstrb;
   logic [1:0]            s_axi_bresp, s_axi_rresp;
   logic                  eeprom_write_done, adc_done, capture_event, compare_event;
   logic                  comparator_out, osc_failover, timer_b_match, timer_a_overflow;
   pib_pkg::pib_cc_mode_t capcomp_mode;
   logic                  peripheral_request, core_irq, irq;
   int                    fail_count, tests_run;
   logic [7:0]            exp;
   int                    src [7] = '{7, 6, 5, 3, 2, 1, 0};

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   pib_top DUT (.clk(clk), .reset(reset),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .eeprom_write_done(eeprom_write_done), .adc_done(adc_done),
      .capture_event(capture_event), .compare_event(compare_event),
      .capcomp_mode(capcomp_mode), .comparator_out(comparator_out),
      .osc_failover(osc_failover), .timer_b_match(timer_b_match),
      .timer_a_overflow(timer_a_overflow), .peripheral_request(peripheral_request),
      .core_irq(core_irq), .irq(irq));

   pib_periph_model u_periph (.clk(clk), .eeprom_write_done(eeprom_write_done),
      .adc_done(adc_done), .capture_event(capture_event), .compare_event(compare_event),
      .capcomp_mode(capcomp_mode), .comparator_out(comparator_out),
      .osc_failover(osc_failover), .timer_b_match(timer_b_match),
      .timer_a_overflow(timer_a_overflow));

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, want, got);
      end
   endtask : check

   task automatic give_up;
      fail_count++;
      $display("[ERR] bus answer expected 1 seen 0");
      final_report();
   endtask : give_up

   task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] want);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (n > 64) give_up();
      end while (s_axi_bvalid !== 1'b1);
      check("bresp", 32'(s_axi_bresp), 32'(want));
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] want);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (n > 64) give_up();
      end while (s_axi_rvalid !== 1'b1);
      check("rresp", 32'(s_axi_rresp), 32'(want));
      check("rdata", s_axi_rdata, {24'h000000, d});
      s_axi_rready <= 1'b0;
   endtask : rd

   // Registered request paths settle within three cycles of their cause.
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask : settle

   // -----------------------------------------------------------------
   // Sequence
   // -----------------------------------------------------------------
   initial begin
      fail_count = 0;
      tests_run = 0;
      reset = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 5'h00;
      s_axi_araddr = 5'h00;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'h0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      rd(A_EN, 8'h00, 2'h0);
      rd(A_FL, 8'h00, 2'h0);
      rd(A_CORE, 8'h00, 2'h0);
      rd(5'h14, 8'h00, 2'h2);
      wr(5'h14, 8'hff, 2'h2);
      wr(A_EN, 8'hff, 2'h0);
      rd(A_EN, 8'hef, 2'h0);
      wr(A_EN, 8'h00, 2'h0);
      for (int m = 0; m < 4; m++) begin
         u_periph.set_mode(pib_pkg::pib_cc_mode_t'(m));
         u_periph.pulse(5);
         u_periph.pulse(8);
         settle();
         rd(A_FL, (m == 1 || m == 2) ? 8'h20 : 8'h00, 2'h0);
         wr(A_FL, 8'h00, 2'h0);
      end
      u_periph.set_mode(pib_pkg::PIB_CC_CAPTURE);
      exp = 8'h00;
      foreach (src[i]) begin
         u_periph.pulse(src[i]);
         settle();
         exp[src[i]] = 1'b1;
         rd(A_FL, exp, 2'h0);
         check("peripheral_request", 32'(peripheral_request), 32'h0);
      end
      settle();
      rd(A_FL, 8'hef, 2'h0);
      wr(A_FL, 8'hff, 2'h0);
      rd(A_FL, 8'hef, 2'h0);
      wr(A_FL, 8'hee, 2'h0);
      rd(A_FL, 8'hee, 2'h0);
      wr(A_FL, 8'h00, 2'h0);
      wr(A_EN, 8'h02, 2'h0);
      u_periph.pulse(0);
      settle();
      check("peripheral_request", 32'(peripheral_request), 32'h0);
      wr(A_EN, 8'h01, 2'h0);
      settle();
      check("peripheral_request", 32'(peripheral_request), 32'h1);
      for (int c = 0; c < 4; c++) begin
         wr(A_CORE, 8'(c), 2'h0);
         settle();
         check("core_irq", 32'(core_irq), 32'(c == 3));
      end
      rd(A_STAT, 8'h03, 2'h0);
      check("irq", 32'(irq), 32'h0);
      wr(A_MASK, 8'h02, 2'h0);
      settle();
      check("irq", 32'(irq), 32'h1);
      wr(A_STAT, 8'h02, 2'h0);
      settle();
      check("irq", 32'(irq), 32'h0);
      rd(A_STAT, 8'h01, 2'h0);
      wr(A_MASK, 8'h01, 2'h0);
      settle();
      check("irq", 32'(irq), 32'h1);
      wr(A_STAT, 8'h01, 2'h0);
      settle();
      check("irq", 32'(irq), 32'h0);
      rd(A_STAT, 8'h00, 2'h0);
      // A reset in mid-run, with the comparator pin left high, clears every
      // register and must not be mistaken for a comparator change.
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      settle();
      check("core_irq", 32'(core_irq), 32'h0);
      check("irq", 32'(irq), 32'h0);
      rd(A_EN, 8'h00, 2'h0);
      rd(A_CORE, 8'h00, 2'h0);
      rd(A_FL, 8'h00, 2'h0);
      u_periph.pulse(3);
      settle();
      rd(A_FL, 8'h08, 2'h0);
      final_report();
   end
endmodule : pib_top_tb
